// >>> src/exc_regs.svh
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_MACHINE_STATE   8'h00
`define OFS_SAVED_RETURN    8'h04
`define OFS_SAVED_STATE     8'h08
`define OFS_FAULT_STATUS    8'h0C
`define OFS_CONTROL         8'h10
`define OFS_STATUS          8'h14

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define MACHINE_STATE_RESET 32'h0000_0040
`define CONTROL_RESET       3'h0
`define SAVE_COPY_MASK      32'h0000_FF73
`define ENTRY_CLEAR_MASK    32'h0004_EF33
`define WORD_ZERO           32'h0000_0000

// ----------------------------------------
// machine state bit positions
// ----------------------------------------
`define BIT_EXT_INT_ENABLE  15
`define BIT_INT_ENDIAN      16
`define BIT_PREFIX          6
`define BIT_DATA_XLATE      4
`define BIT_ENDIAN          0

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define CTL_EXT_ACCESS      0
`define CTL_NO_DCACHE       1
`define CTL_WT_DCACHE       2

// ----------------------------------------
// vectors
// ----------------------------------------
`define BASE_LOW            32'h0000_0000
`define BASE_HIGH           32'hFFF0_0000
`define VEC_EXT_INT         32'h0000_0500
`define VEC_ALIGN           32'h0000_0600

// ----------------------------------------
// instruction and address fields
// ----------------------------------------
`define OPCODE_INDEXED      6'h1F
`define PAGE_MSB            11
`define SEG_LSB             28

`endif

// >>> src/exc_pkg.sv
package exc_pkg;

	typedef enum logic [2:0]
	{
		OP_ELEM   = 3'h0,
		OP_FLOAT  = 3'h1,
		OP_MULT   = 3'h2,
		OP_STRING = 3'h3,
		OP_RESV   = 3'h4,
		OP_EXTCTL = 3'h5,
		OP_DCBZ   = 3'h6
	} op_t;

	typedef enum logic [2:0]
	{
		ST_RUN   = 3'b001,
		ST_ENTER = 3'b010,
		ST_HOLD  = 3'b100
	} state_t;

	typedef struct packed
	{
		logic        valid;
		op_t         op;
		logic [31:0] addr;
		logic [7:0]  size;
		logic [31:0] instr;
		logic [31:0] pc;
		logic        write_through;
		logic        cache_inhibit;
		logic        direct_store;
		logic        bat_cross;
		logic        unmapped_cross;
	} access_req_t;

	typedef struct packed
	{
		logic        taken;
		logic        is_align;
		logic [31:0] vector;
		logic        go;
		logic        dsi;
		logic        dcbz_clear;
		logic [31:0] clear_addr;
	} exc_resp_t;

endpackage

// >>> src/extint_alignment_exception_unit.sv
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`include "exc_regs.svh"

// Functional notes
// - defer interrupt on higher exception or disabled
// - entry never clears the outside request
// - interrupt saves next instruction address
// - interrupt vectors to 0x500 plus prefix base
// - entry rewrites machine state, endian from interrupt
// - alignment clears saved bits 1-4, 10-15
// - alignment copies listed machine state bits
// - alignment saves faulting instruction address
// - alignment vectors to 0x600 offset
// - alignment only when no higher exception
// - unaligned float access faults
// - little endian multiple/string always faults
// - optional unaligned cases trap here
// - misaligned external control with access off goes dsi
// - elementary/string protection crossing faults
// - multiple crossing segment or region faults
// - zeroing block faults on cache attributes
// - allowed block zeroing clears whole block
// - float to direct-store segment faults
// - segment, region, page, unmapped are domains
// - domains only with translation enabled
// - fault status from instruction fields
module extint_alignment_exception_unit
#(
	parameter int BLOCK_BYTES = 32
)
(
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                ext_int_req,
	input  wire logic                higher_exc,
	input  wire logic [31:0]         next_pc,
	input  wire exc_pkg::access_req_t access_req,
	output exc_pkg::exc_resp_t       resp,
	output logic      [31:0]         machine_state
);
	import exc_pkg::*;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	state_t      state;
	logic [31:0] saved_return_address;
	logic [31:0] saved_machine_state;
	logic [31:0] data_fault_status;
	logic [2:0]  control;
	logic        wb_hit;
	logic        wb_wr;
	logic [31:0] next_rd;
	logic        take_int;
	logic        take_align;
	logic        take_dsi;
	logic        align_cond;
	logic        dsi_cond;
	logic        req_ok;
	logic [31:0] base;
	logic [31:0] entry_state;
	logic [31:0] saved_image;
	logic [31:0] last_byte;
	logic        page_cross;
	logic        seg_cross;
	logic        domain_cross;
	logic        word_mis;
	logic        little;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] fault_image(input logic [31:0] ins);
		logic [31:0] d;
		logic        idx;
		d = `WORD_ZERO;
		idx = (ins[31:26] == `OPCODE_INDEXED);
		d[16:15] = idx ? ins[2:1] : 2'h0;
		d[14] = idx ? ins[6] : ins[26];
		d[13:10] = idx ? ins[10:7] : ins[30:27];
		d[9:5] = ins[25:21];
		d[4:0] = ins[20:16];
		return d;
	endfunction

	function automatic logic wr_to(input logic [7:0] ofs, input logic wr,
		input logic [7:0] adr);
		return wr && (adr == ofs);
	endfunction

	// ----------------------------------------
	// alignment evaluation
	// ----------------------------------------
	always_comb
	begin
		little = machine_state[`BIT_ENDIAN];
		last_byte = access_req.addr + {24'h00_0000, access_req.size} - 32'h0000_0001;
		page_cross = (access_req.size != 8'h00) &&
			(last_byte[31:`PAGE_MSB+1] != access_req.addr[31:`PAGE_MSB+1]);
		seg_cross = (access_req.size != 8'h00) &&
			(last_byte[31:`SEG_LSB] != access_req.addr[31:`SEG_LSB]);
		domain_cross = machine_state[`BIT_DATA_XLATE] &&
			(page_cross || seg_cross || access_req.bat_cross
			|| access_req.unmapped_cross);
		word_mis = (access_req.addr[1:0] != 2'h0);
		align_cond = 1'b0;
		dsi_cond = 1'b0;
		case (access_req.op)
			OP_FLOAT:
			begin
				align_cond = word_mis || access_req.direct_store
					|| domain_cross;
			end
			OP_MULT:
			begin
				align_cond = little || word_mis
					|| (machine_state[`BIT_DATA_XLATE] &&
					(seg_cross || access_req.bat_cross));
			end
			OP_STRING:
			begin
				align_cond = little || domain_cross;
			end
			OP_RESV:
			begin
				align_cond = word_mis || domain_cross;
			end
			OP_EXTCTL:
			begin
				dsi_cond = word_mis && !control[`CTL_EXT_ACCESS];
				align_cond = (word_mis && control[`CTL_EXT_ACCESS])
					|| domain_cross;
			end
			OP_DCBZ:
			begin
				align_cond = access_req.write_through || access_req.cache_inhibit
					|| control[`CTL_NO_DCACHE] || control[`CTL_WT_DCACHE];
			end
			OP_ELEM:
			begin
				align_cond = domain_cross;
			end
			default:
			begin
				align_cond = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// exception selection
	// ----------------------------------------
	always_comb
	begin
		req_ok = (state == ST_RUN) && access_req.valid && !higher_exc;
		take_align = req_ok && align_cond;
		take_dsi = req_ok && !align_cond && dsi_cond;
		take_int = (state == ST_RUN) && !higher_exc && !take_align && !take_dsi
			&& ext_int_req
			&& machine_state[`BIT_EXT_INT_ENABLE];
		base = machine_state[`BIT_PREFIX] ? `BASE_HIGH : `BASE_LOW;
		entry_state = machine_state & ~`ENTRY_CLEAR_MASK;
		entry_state[`BIT_ENDIAN] = machine_state[`BIT_INT_ENDIAN];
		saved_image = machine_state & `SAVE_COPY_MASK;
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_RUN;
		end
		else
		begin
			case (state)
				ST_RUN:
				begin
					if (take_int || take_align)
					begin
						state <= ST_ENTER;
					end
				end
				ST_ENTER:
				begin
					state <= ST_HOLD;
				end
				ST_HOLD:
				begin
					state <= ST_RUN;
				end
				default:
				begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_hit && wb_we_i;

	always_comb
	begin
		case (wb_adr_i)
			`OFS_MACHINE_STATE: next_rd = machine_state;
			`OFS_SAVED_RETURN:  next_rd = saved_return_address;
			`OFS_SAVED_STATE:   next_rd = saved_machine_state;
			`OFS_FAULT_STATUS:  next_rd = data_fault_status;
			`OFS_CONTROL:       next_rd = {29'h0, control};
			`OFS_STATUS:        next_rd = {29'h0, state};
			default:            next_rd = `WORD_ZERO;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `WORD_ZERO;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			wb_dat_o <= wb_hit ? next_rd : `WORD_ZERO;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control <= `CONTROL_RESET;
		end
		else if (wr_to(`OFS_CONTROL, wb_wr, wb_adr_i) && wb_sel_i[0])
		begin
			control <= wb_dat_i[2:0];
		end
	end

	// ----------------------------------------
	// machine state
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			machine_state <= `MACHINE_STATE_RESET;
		end
		else if (take_int || take_align)
		begin
			machine_state <= entry_state;
		end
		else if (wr_to(`OFS_MACHINE_STATE, wb_wr, wb_adr_i))
		begin
			machine_state <= merge_bytes(machine_state, wb_dat_i, wb_sel_i);
		end
	end

	// ----------------------------------------
	// save/restore registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			saved_return_address <= `WORD_ZERO;
		end
		else if (take_align)
		begin
			saved_return_address <= access_req.pc;
		end
		else if (take_int)
		begin
			saved_return_address <= next_pc;
		end
		else if (wr_to(`OFS_SAVED_RETURN, wb_wr, wb_adr_i))
		begin
			saved_return_address <= merge_bytes(saved_return_address, wb_dat_i,
				wb_sel_i);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			saved_machine_state <= `WORD_ZERO;
		end
		else if (take_int || take_align)
		begin
			saved_machine_state <= saved_image;
		end
		else if (wr_to(`OFS_SAVED_STATE, wb_wr, wb_adr_i))
		begin
			saved_machine_state <= merge_bytes(saved_machine_state, wb_dat_i,
				wb_sel_i);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_fault_status <= `WORD_ZERO;
		end
		else if (take_align)
		begin
			data_fault_status <= fault_image(access_req.instr);
		end
		else if (wr_to(`OFS_FAULT_STATUS, wb_wr, wb_adr_i))
		begin
			data_fault_status <= merge_bytes(data_fault_status, wb_dat_i,
				wb_sel_i);
		end
	end

	// ----------------------------------------
	// response to pipeline
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resp <= '0;
		end
		else
		begin
			resp.taken <= take_int || take_align;
			resp.is_align <= take_align;
			resp.vector <= take_align ? base + `VEC_ALIGN
				: (take_int ? base + `VEC_EXT_INT : `WORD_ZERO);
			resp.go <= req_ok && !align_cond && !dsi_cond;
			resp.dsi <= take_dsi;
			resp.dcbz_clear <= req_ok && !align_cond
				&& (access_req.op == OP_DCBZ);
			resp.clear_addr <= access_req.addr
				& ~(BLOCK_BYTES[31:0] - 32'h0000_0001);
		end
	end

	// the outside request is only sampled, never acknowledged here

endmodule

// >>> tb/exc_unit_properties.sv
module exc_unit_properties
#(
	parameter int BLOCK_BYTES = 32
)
(
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_ack_o,
	input  wire logic                 ext_int_req,
	input  wire logic                 higher_exc,
	input  wire exc_pkg::access_req_t access_req,
	input  wire exc_pkg::exc_resp_t   resp,
	input  wire logic [31:0]          machine_state
);
	timeunit 1ns;
	timeprecision 1ns;
	import exc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ----
	// sequences
	// ----
	sequence s_int_entry;
		resp.taken && !resp.is_align;
	endsequence
	sequence s_quiet;
		!resp.taken [*2];
	endsequence
	// ----
	// checks
	// ----
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not acknowledged");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_int_vector: assert property (
		s_int_entry |-> resp.vector == (machine_state[6] ? 32'hFFF0_0500 : 32'h0000_0500))
		else $error("interrupt vector wrong");
	a_align_vector: assert property (
		resp.taken && resp.is_align
		|-> resp.vector == (machine_state[6] ? 32'hFFF0_0600 : 32'h0000_0600))
		else $error("alignment vector wrong");
	a_int_gated: assert property (
		s_int_entry |-> $past(ext_int_req && machine_state[15] && !higher_exc))
		else $error("interrupt taken while held off");
	a_align_cause: assert property (
		resp.taken && resp.is_align |-> $past(access_req.valid && !higher_exc))
		else $error("alignment entry without cause");
	a_entry_state: assert property (
		resp.taken |-> (machine_state & 32'h0004_EF32) == 32'h0000_0000
		&& machine_state[0] == machine_state[16] && $stable(machine_state[12]))
		else $error("machine state after entry wrong");
	a_busy_window: assert property (resp.taken |=> s_quiet)
		else $error("entry during busy window");
	a_block_clear: assert property (
		resp.dcbz_clear |-> resp.clear_addr % BLOCK_BYTES == 0)
		else $error("block clear address not aligned");
endmodule

// >>> tb/int_requester.sv
module int_requester
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic raise,
	input  wire logic serviced,
	output logic      ext_int_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// level request held until serviced
	// ----
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ext_int_req <= 1'b0;
		else if (serviced)
			ext_int_req <= 1'b0;
		else if (raise)
			ext_int_req <= 1'b1;
	end
endmodule

// >>> tb/extint_alignment_exception_unit_tb.sv
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			err_count++; \
			$display("ERROR %s expected %h seen %h", nm, ex, got); \
		end \
	end

module extint_alignment_exception_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import exc_pkg::*;
	logic        clock;
	logic        rst_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ext_int_req;
	logic        higher_exc;
	logic [31:0] next_pc;
	access_req_t access_req;
	exc_resp_t   resp;
	logic [31:0] machine_state;
	logic        raise;
	logic        serviced;
	logic [31:0] exp_vec[$];
	logic [31:0] exp_rd[$];
	logic [34:0] exp_ok[$];
	logic [31:0] e_v;
	logic [34:0] e_o;
	int          err_count;
	int          checks_done;

	extint_alignment_exception_unit #(.BLOCK_BYTES(32)) i_extint_alignment_exception_unit
	(
		.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .ext_int_req, .higher_exc, .next_pc, .access_req, .resp,
		.machine_state
	);
	int_requester i_int_requester (.clock, .rst_n, .raise, .serviced, .ext_int_req);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----
	// helpers
	// ----
	function automatic logic [31:0] entry(input logic [31:0] m);
		entry = m & ~32'h0004_EF33;
		entry[0] = m[16];
	endfunction

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] ex);
		exp_rd.push_back(ex);
		wb(1'b0, adr, 32'h0000_0000);
	endtask

	task automatic pipe(input access_req_t r, input logic hit, input logic [31:0] vec,
		input logic dsi);
		if (hit)
			exp_vec.push_back(vec);
		else
			exp_ok.push_back({!dsi, dsi, !dsi && r.op == OP_DCBZ, r.addr & 32'hFFFF_FFE0});
		@(posedge clock);
		access_req <= r;
		@(posedge clock);
		access_req <= '0;
		repeat (4) @(posedge clock);
	endtask

	task automatic test_done;
		if (exp_vec.size() != 0 || exp_rd.size() != 0 || exp_ok.size() != 0)
			err_count++;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----
	// result monitor
	// ----
	always @(posedge clock)
	begin
		if (resp.taken === 1'b1)
		begin
			e_v = (exp_vec.size() == 0) ? 32'hDEAD_0000 : exp_vec.pop_front();
			`CHK("entry vector", e_v, resp.vector)
		end
		if (resp.go === 1'b1 || resp.dsi === 1'b1)
		begin
			e_o = (exp_ok.size() == 0) ? 35'h7_FFFF_FFFF : exp_ok.pop_front();
			`CHK("access result", e_o, {resp.go, resp.dsi, resp.dcbz_clear, resp.clear_addr})
		end
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			e_v = exp_rd.pop_front();
			`CHK("read data", e_v, wb_dat_o)
		end
	end

	initial
	begin
		repeat (5000) @(posedge clock);
		err_count++;
		test_done();
	end

	// ----
	// tests
	// ----
	initial
	begin
		logic [31:0] ms;
		logic [31:0] pc;
		access_req_t r;
		op_t         ops[5];
		op_t         xo[10];
		logic [31:0] xa[10];
		logic [7:0]  xz[10];
		int          xk[10];
		void'($urandom(75272));
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, raise, serviced, higher_exc} = '0;
		{wb_adr_i, wb_dat_i, access_req} = '0;
		wb_sel_i = 4'hF;
		next_pc = $urandom;
		ops = '{OP_MULT, OP_STRING, OP_DCBZ, OP_DCBZ, OP_DCBZ};
		xo = '{OP_ELEM, OP_ELEM, OP_ELEM, OP_MULT, OP_RESV, OP_EXTCTL, OP_EXTCTL, OP_FLOAT,
			OP_DCBZ, OP_DCBZ};
		xa = '{32'h0000_0FFE, 32'h0000_0FFE, 32'h0000_1000, 32'h0FFF_FFF8, 32'h0000_1002,
			32'h0000_1002, 32'h0000_1002, 32'h0000_1000, 32'h0000_1040, 32'h0000_1050};
		xz = '{8'h04, 8'h04, 8'h04, 8'h10, 8'h04, 8'h04, 8'h04, 8'h04, 8'h20, 8'h20};
		xk = '{1, 0, 1, 1, 1, 2, 1, 1, 1, 0};
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(8'h00, 32'h0000_0040);
		rd(8'h14, 32'h0000_0001);
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000);
		pc = $urandom;
		wb(1'b1, 8'h04, pc);
		rd(8'h04, pc);
		$display("bus test done");
		for (int i = 0; i < 4; i++)
		begin
			ms = $urandom;
			wb(1'b1, 8'h00, ms);
			r = '0;
			r.valid = 1'b1;
			r.op = OP_FLOAT;
			r.size = 8'h04;
			r.addr = ($urandom & 32'hFFFF_FFFC) | i;
			r.pc = $urandom;
			r.instr = i[0] ? 32'h7CA3_0544 : 32'hC0E9_1234;
			pipe(r, i != 0, (ms[6] ? 32'hFFF0_0000 : 32'h0000_0000) + 32'h0000_0600, 1'b0);
			if (i != 0)
			begin
				rd(8'h04, r.pc);
				rd(8'h08, ms & 32'h0000_FF73);
				rd(8'h00, entry(ms));
				rd(8'h0C, i[0] ? 32'h0001_68A3 : 32'h0000_20E9);
			end
		end
		$display("float alignment test done");
		for (int j = 0; j < 5; j++)
		begin
			wb(1'b1, 8'h00, 32'h0000_0041);
			r = '0;
			r.valid = 1'b1;
			r.op = ops[j];
			r.size = 8'h08;
			r.addr = $urandom & 32'hFFFF_FFF8;
			r.cache_inhibit = (j == 2);
			r.write_through = (j == 4);
			pipe(r, j != 3, 32'hFFF0_0600, 1'b0);
		end
		$display("mode and block test done");
		for (int k = 0; k < 10; k++)
		begin
			ms = (k == 0 || k == 2 || k == 3) ? 32'h0000_0010 : 32'h0000_0000;
			wb(1'b1, 8'h00, ms);
			wb(1'b1, 8'h10, (k == 6) ? 32'h0000_0001 : ((k == 8) ? 32'h0000_0002 : 32'h0000_0000));
			r = '0;
			r.valid = 1'b1;
			r.op = xo[k];
			r.addr = xa[k];
			r.size = xz[k];
			r.bat_cross = (k == 2);
			r.direct_store = (k == 7);
			pipe(r, xk[k] == 1, 32'h0000_0600, xk[k] == 2);
		end
		$display("domain and control test done");
		wb(1'b1, 8'h00, 32'h0000_0000);
		pc = $urandom;
		next_pc <= pc;
		raise <= 1'b1;
		higher_exc <= 1'b1;
		@(posedge clock);
		raise <= 1'b0;
		repeat (4) @(posedge clock);
		exp_vec.push_back(32'h0000_0500);
		wb(1'b1, 8'h00, 32'h0001_8000);
		repeat (5) @(posedge clock);
		higher_exc <= 1'b0;
		repeat (8) @(posedge clock);
		rd(8'h04, pc);
		rd(8'h00, 32'h0001_0001);
		rd(8'h08, 32'h0000_8000);
		exp_vec.push_back(32'h0000_0500);
		wb(1'b1, 8'h00, 32'h0000_8000);
		repeat (4) @(posedge clock);
		serviced <= 1'b1;
		@(posedge clock);
		serviced <= 1'b0;
		wb(1'b1, 8'h00, 32'h0000_8000);
		repeat (6) @(posedge clock);
		$display("interrupt test done");
		test_done();
	end
endmodule

bind extint_alignment_exception_unit exc_unit_properties #(.BLOCK_BYTES(BLOCK_BYTES))
	i_exc_unit_properties
(
	.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ext_int_req, .higher_exc, .access_req,
	.resp, .machine_state
);
